// ===== logic/psc_defs.svh
// Purpose: Constants for the receive statistics counter bank.
// Assumes: Host registers are 16 bits wide, byte addressed.
// Notes: Offsets, fields and limits used by psc_counters.
//
// Contract
// - Thirty-two counters per port, each read as a 32-bit word indirectly.
// - Word bit 31 reads one after the counter overflowed.
// - Word bit 30 reads one when the returned value is valid.
// - Bits 29..0 hold the count; reset zero, cleared on each read.
// - Counters sit at indirect offsets 0x00 through 0x1F.
// - Command starts a read; low half and high half in two data registers.
// - Offsets 0x0/0x1 add octets of low/high priority frames, bad included.
// - Offset 0x2 counts short frames with correct CRC.
// - Offset 0x3 counts short frames with CRC, symbol or alignment error.
// - Offset 0x4 counts long good-CRC frames up to 2000 bytes.
// - Offset 0x5 counts long frames with errors; limit follows max size.
// - Offset 0x6 counts legal-length frames with an invalid symbol.
// - Offset 0x7 counts legal whole-byte frames with bad CRC.
// - Offset 0x8 counts legal partial-byte frames with bad CRC.
// - Offset 0x9 counts MAC control frames of type 88-08h.
// - Offset 0xA counts qualified pause frames.
// - Offset 0xB counts good broadcast frames only.
// - Offset 0xC counts good multicast, not control, not broadcast.
// - Offset 0xD counts good single-station frames.
// - Offset 0xE counts all frames exactly 64 octets long.
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ==========================================================
// Host register addresses
`define PSC_ADDR_CMD 11'h020
`define PSC_ADDR_LOW 11'h02c
`define PSC_ADDR_HIGH 11'h02e

// ==========================================================
// Command and word fields
`define PSC_CMD_RD_BIT 12
`define PSC_CMD_TBL_HI 11
`define PSC_CMD_TBL_LO 10
`define PSC_CMD_TBL_STATS 2'h3
`define PSC_CMD_OFS_HI 9
`define PSC_WORD_OVF 31
`define PSC_WORD_VALID 30

// ==========================================================
// Counter offsets
`define PSC_OFS_LO_OCT 0
`define PSC_OFS_HI_OCT 1
`define PSC_OFS_SHORT_GOOD 2
`define PSC_OFS_SHORT_BAD 3
`define PSC_OFS_LONG_GOOD 4
`define PSC_OFS_LONG_BAD 5
`define PSC_OFS_BAD_SYM 6
`define PSC_OFS_CRC_FAIL 7
`define PSC_OFS_PARTIAL 8
`define PSC_OFS_MAC_CTRL 9
`define PSC_OFS_PAUSE 10
`define PSC_OFS_ALL_STN 11
`define PSC_OFS_GROUP 12
`define PSC_OFS_SINGLE 13
`define PSC_OFS_MIN_SIZE 14
`define PSC_OFS_BIN0 15

// ==========================================================
// Frame length limits in octets
`define PSC_LEN_MIN 11'h040
`define PSC_LEN_LONG_CAP 11'h7d0
`define PSC_LEN_MAX_DEF 11'h5f2
`define PSC_LEN_BIN0 11'h041
`define PSC_LEN_BIN1 11'h080
`define PSC_LEN_BIN2 11'h100
`define PSC_LEN_BIN3 11'h200
`define PSC_LEN_BIN4 11'h400

`endif

// ===== logic/psc_pkg.sv
// Purpose: Types for the receive statistics counter bank.
// Assumes: Nothing beyond the standard language.
// Notes: Constants live in psc_defs.svh.
`default_nettype none

package psc_pkg;
  // ==========================================================
  // Indirect read sequencing
  typedef enum logic {
    PSC_RD_IDLE,
    PSC_RD_CAPTURE
  } psc_rd_state_type;
endpackage : psc_pkg

`default_nettype wire

// ===== logic/psc_counters.sv
// Purpose: Receive statistics counters with indirect host reads.
// Assumes: Frame descriptor arrives as one pulse at frame end.
// Notes: Counters above the receive set have no source here.
`include "psc_defs.svh"
`default_nettype none

module psc_counters #(
  parameter int NUM_CNT = 32,
  parameter int CNT_W = 30,
  parameter int LEN_W = 11
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [10:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  input wire logic frameDone,
  input wire logic [LEN_W-1:0] frameLen,
  input wire logic [LEN_W-1:0] maxFrameLen,
  input wire logic frameHighPrio,
  input wire logic crcOk,
  input wire logic symbolErr,
  input wire logic partialByte,
  input wire logic macCtrlType,
  input wire logic pauseDestOk,
  input wire logic pauseOpcodeOk,
  input wire logic allStation,
  input wire logic groupAddr
);

  // ==========================================================
  // Elaboration checks
  if (NUM_CNT != 32 || CNT_W != 30 || LEN_W != 11) begin : gBadParam
    $error("psc_counters: bank shape must be 32 x 30 bits, 11-bit length");
  end

  // ==========================================================
  // Reset release through two flops
  logic rstSync1_r;
  logic rstSync2_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  wire logic rstN = rstSync2_r;

  // ==========================================================
  // Frame classification
  logic [NUM_CNT-1:0] evt;
  logic legalLen;
  logic isShort;
  logic isLong;
  logic anyErr;
  logic isGood;
  always_comb begin
    isShort = frameLen < `PSC_LEN_MIN;
    isLong = frameLen > maxFrameLen;
    legalLen = !isShort && !isLong;
    anyErr = !crcOk || symbolErr || partialByte;
    isGood = !anyErr;
    evt = '0;
    evt[`PSC_OFS_SHORT_GOOD] = isShort && crcOk;
    evt[`PSC_OFS_SHORT_BAD] = isShort && anyErr;
    evt[`PSC_OFS_LONG_GOOD] = isLong && crcOk &&
      frameLen <= `PSC_LEN_LONG_CAP;
    evt[`PSC_OFS_LONG_BAD] = isLong && anyErr;
    evt[`PSC_OFS_BAD_SYM] = legalLen && symbolErr;
    evt[`PSC_OFS_CRC_FAIL] = legalLen && !crcOk && !partialByte;
    evt[`PSC_OFS_PARTIAL] = legalLen && !crcOk && partialByte;
    evt[`PSC_OFS_MAC_CTRL] = macCtrlType;
    evt[`PSC_OFS_PAUSE] = macCtrlType && pauseDestOk && pauseOpcodeOk &&
      !isShort && crcOk;
    evt[`PSC_OFS_ALL_STN] = isGood && allStation;
    evt[`PSC_OFS_GROUP] = isGood && groupAddr && !allStation &&
      !macCtrlType;
    evt[`PSC_OFS_SINGLE] = isGood && !groupAddr && !allStation;
    evt[`PSC_OFS_MIN_SIZE] = frameLen == `PSC_LEN_MIN;
    // Size bins, bad frames included
    evt[`PSC_OFS_BIN0] = frameLen >= `PSC_LEN_BIN0 &&
      frameLen < `PSC_LEN_BIN1;
    evt[`PSC_OFS_BIN0+1] = frameLen >= `PSC_LEN_BIN1 &&
      frameLen < `PSC_LEN_BIN2;
    evt[`PSC_OFS_BIN0+2] = frameLen >= `PSC_LEN_BIN2 &&
      frameLen < `PSC_LEN_BIN3;
    evt[`PSC_OFS_BIN0+3] = frameLen >= `PSC_LEN_BIN3 &&
      frameLen < `PSC_LEN_BIN4;
    evt[`PSC_OFS_BIN0+4] = frameLen >= `PSC_LEN_BIN4 && !isLong;
    if (!frameDone) begin
      evt = '0;
    end
  end

  // Per-counter addend: octet counters take the length, others one
  logic [CNT_W-1:0] incr [NUM_CNT];
  always_comb begin
    for (int i = 0; i < NUM_CNT; i++) begin
      incr[i] = {{(CNT_W-1){1'b0}}, evt[i]};
    end
    incr[`PSC_OFS_LO_OCT] = (frameDone && !frameHighPrio) ?
      {{(CNT_W-LEN_W){1'b0}}, frameLen} : '0;
    incr[`PSC_OFS_HI_OCT] = (frameDone && frameHighPrio) ?
      {{(CNT_W-LEN_W){1'b0}}, frameLen} : '0;
  end

  // ==========================================================
  // Host side state
  psc_pkg::psc_rd_state_type rdState_r;
  psc_pkg::psc_rd_state_type rdState_nxt;
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic [15:0] regRdata_r;
  logic [15:0] regRdata_nxt;
  logic [4:0] selIdx;
  logic inBank;
  logic cmdHit;

  // Counter bank, kept in flops so every entry can move each cycle
  logic [CNT_W-1:0] cnt_r [NUM_CNT];
  logic [CNT_W-1:0] cnt_nxt [NUM_CNT];
  logic [NUM_CNT-1:0] ovf_r;
  logic [NUM_CNT-1:0] ovf_nxt;

  // Offset decode shared by read clear and capture
  function automatic logic bank_hit(input logic [15:0] c);
    bank_hit = c[`PSC_CMD_OFS_HI:5] == '0;
  endfunction : bank_hit

  always_comb begin
    selIdx = cmd_r[4:0];
    inBank = bank_hit(cmd_r);
    cmdHit = regWrite && regAddr == `PSC_ADDR_CMD;
  end

  // ==========================================================
  // Counter update: a read clears first, then this cycle's event adds,
  // so an event landing on the read is kept in the fresh count
  always_comb begin
    logic [CNT_W:0] sum;
    sum = '0;
    for (int i = 0; i < NUM_CNT; i++) begin
      cnt_nxt[i] = cnt_r[i];
      ovf_nxt[i] = ovf_r[i];
      if (rdState_r == psc_pkg::PSC_RD_CAPTURE && inBank &&
          selIdx == i[4:0]) begin
        cnt_nxt[i] = '0;
        ovf_nxt[i] = 1'b0;
      end
      sum = {1'b0, cnt_nxt[i]} + {1'b0, incr[i]};
      cnt_nxt[i] = sum[CNT_W-1:0];
      if (sum[CNT_W]) begin
        ovf_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        cnt_r[i] <= '0;
      end
      ovf_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  // ==========================================================
  // Indirect access: a stats read command write drops valid, capture one cycle later
  always_comb begin
    rdState_nxt = psc_pkg::PSC_RD_IDLE;
    cmd_nxt = cmd_r;
    word_nxt = word_r;
    regRdata_nxt = regRdata_r;
    if (rdState_r == psc_pkg::PSC_RD_CAPTURE) begin
      word_nxt = '0;
      word_nxt[`PSC_WORD_VALID] = 1'b1;
      if (inBank) begin
        word_nxt[`PSC_WORD_OVF] = ovf_r[selIdx];
        word_nxt[CNT_W-1:0] = cnt_r[selIdx];
      end
    end
    if (cmdHit) begin
      cmd_nxt = regWdata;
      if (regWdata[`PSC_CMD_RD_BIT] && regWdata[`PSC_CMD_TBL_HI:
          `PSC_CMD_TBL_LO] == `PSC_CMD_TBL_STATS) begin
        word_nxt = '0;
        rdState_nxt = psc_pkg::PSC_RD_CAPTURE;
      end
    end
    if (regRead) begin
      unique case (regAddr)
        `PSC_ADDR_CMD: regRdata_nxt = cmd_r;
        `PSC_ADDR_LOW: regRdata_nxt = word_r[15:0];
        `PSC_ADDR_HIGH: regRdata_nxt = word_r[31:16];
        default: regRdata_nxt = '0; // Unmapped reads return zero
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdState_r <= psc_pkg::PSC_RD_IDLE;
      cmd_r <= '0;
      word_r <= '0;
      regRdata_r <= '0;
    end else begin
      rdState_r <= rdState_nxt;
      cmd_r <= cmd_nxt;
      word_r <= word_nxt;
      regRdata_r <= regRdata_nxt;
    end
  end

  assign regRdata = regRdata_r;

endmodule : psc_counters

`default_nettype wire

// ===== tb/psc_monitor.sv
// Purpose: Host-side checks for the statistics bank.
// Assumes: Register map of psc_defs.svh.
// Notes: Frame inputs are left to the bench model.
`include "psc_defs.svh"
`default_nettype none
module psc_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [10:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic cmd;
  logic hiRd;
  logic loRd;
  // ==========
  // Decoded host accesses
  assign cmd = regWrite && regAddr == `PSC_ADDR_CMD && regWdata[12]
    && regWdata[11:10] == 2'h3;
  assign hiRd = regRead && !regWrite && regAddr == `PSC_ADDR_HIGH;
  assign loRd = regRead && !regWrite && regAddr == `PSC_ADDR_LOW;
  // ==========
  // Properties; idle offsets never count, so their word is fixed
  property p_unmap;
    regRead && !(regAddr inside {`PSC_ADDR_CMD, `PSC_ADDR_LOW,
      `PSC_ADDR_HIGH}) |=> regRdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_hold;
    !regRead |=> $stable(regRdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_early;
    cmd ##1 hiRd |=> regRdata == 16'h0000;
  endproperty
  a_early: assert property (p_early) else $error("early word");
  property p_valid;
    cmd ##1 (!regWrite)[*3] ##1 hiRd |=> regRdata[14];
  endproperty
  a_valid: assert property (p_valid) else $error("word not valid");
  property p_idleHi;
    (cmd && regWdata[9:0] >= 10'h014) ##1 (!regWrite)[*3] ##1 hiRd
      |=> regRdata == 16'h4000;
  endproperty
  a_idleHi: assert property (p_idleHi) else $error("idle high");
  property p_idleLo;
    (cmd && regWdata[9:0] >= 10'h014) ##1 (!regWrite)[*6] ##1 loRd
      |=> regRdata == 16'h0000;
  endproperty
  a_idleLo: assert property (p_idleLo) else $error("idle low");
  property p_restart;
    cmd ##2 cmd ##1 (!regWrite)[*3] ##1 hiRd |=> regRdata == 16'h4000;
  endproperty
  a_restart: assert property (p_restart) else $error("not cleared");
  property p_reset;
    $rose(rst_b) |-> regRdata == 16'h0000;
  endproperty
  a_reset: assert property (p_reset) else $error("reset data");
endmodule : psc_monitor

bind psc_counters psc_monitor psc_monitor_inst (.clk(clk), .rst_b(rst_b),
  .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
  .regWdata(regWdata), .regRdata(regRdata));
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for psc_counters.
// Assumes: No frame arrives during a counter read.
// Notes: Overflow needs 2^30 events, so neither bench nor assertions check it.
`include "psc_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic frameDone = 1'b0, hp = 1'b0, crc = 1'b0, sym = 1'b0, part = 1'b0;
  logic mac = 1'b0, pd = 1'b0, po = 1'b0, bc = 1'b0, mc = 1'b0;
  logic [10:0] regAddr = 11'h000, len = 11'h000, mx = 11'h5f2;
  logic [15:0] regWdata = 16'h0000, regRdata, d;
  logic [31:0] seed = 32'h00012510;
  int failures = 0, n_tests = 0, n, o;
  int unsigned cnt[33];
  int bnd[6] = '{32'h41, 32'h80, 32'h100, 32'h200, 32'h400, 32'h5f3};
  // ==========
  // Clock, design and helpers
  always #4 clk = ~clk;
  psc_counters psc_counters_inst (.clk(clk), .rst_b(rst_b),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .frameDone(frameDone),
    .frameLen(len), .maxFrameLen(mx), .frameHighPrio(hp),
    .crcOk(crc), .symbolErr(sym), .partialByte(part), .macCtrlType(mac),
    .pauseDestOk(pd), .pauseOpcodeOk(po), .allStation(bc), .groupAddr(mc));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wr(logic [10:0] a, logic [15:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // Data is sampled a cycle late; it holds until the next read anyway
  task automatic rd(logic [10:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    #1 d = regRdata;
  endtask : rd
  // One counter read: early high read, retries, then the low half
  task automatic rdctr(int c);
    logic [31:0] w;
    int k;
    w = {2'b01, cnt[c][29:0]};
    cnt[c] = 0;
    wr(`PSC_ADDR_CMD, 16'h1c00 | 16'(c));
    regRead <= 1'b1;
    regAddr <= `PSC_ADDR_HIGH;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    #1 chk("early high", regRdata, 16'h0000);
    d = regRdata;
    for (k = 0; k < 4 && !d[14]; k++) rd(`PSC_ADDR_HIGH);
    chk("high half", d, w[31:16]);
    rd(`PSC_ADDR_LOW);
    chk("low half", d, w[15:0]);
  endtask : rdctr
  // Back-to-back frames; symbol errors only at legal length
  // Size limit is moved per round so the long and legal ranges follow it
  task automatic frames(int cntF, int lim);
    int i, l, m, g, lg, b;
    logic [31:0] r;
    @(posedge clk);
    mx <= 11'(lim);
    bnd[5] = lim + 1;
    for (i = 0; i < cntF; i++) begin
      r = xs();
      l = (i < 12) ? bnd[i % 6] - i / 6 : int'(r[10:0]) | 32'h1;
      lg = l >= 32'h40 && l <= lim;
      m = (r[12:11] == 2'h3 && !lg) ? 32'h1 : int'(r[12:11]);
      g = m == 0;
      @(posedge clk);
      frameDone <= 1'b1;
      len <= 11'(l);
      hp <= r[18];
      crc <= m == 0 || m == 3;
      sym <= m == 3;
      part <= m == 2;
      mac <= r[13] && g;
      pd <= r[14];
      po <= r[15];
      bc <= r[16];
      mc <= r[16] || r[17];
      cnt[r[18]] += l;
      cnt[2] += l < 32'h40 && g;
      cnt[3] += l < 32'h40 && !g;
      cnt[4] += l > lim && l <= 32'h7d0 && g;
      cnt[5] += l > lim && !g;
      cnt[6] += lg && m == 3;
      cnt[7] += lg && m == 1;
      cnt[8] += lg && m == 2;
      cnt[9] += r[13] && g;
      cnt[10] += r[13] && g && r[14] && r[15] && l >= 32'h40;
      cnt[11] += g && r[16];
      cnt[12] += g && r[17] && !r[16] && !r[13];
      cnt[13] += g && !r[16] && !r[17];
      cnt[14] += l == 32'h40;
      for (b = 0; b < 5; b++) cnt[15 + b] += l >= bnd[b] && l < bnd[b + 1];
    end
    @(posedge clk);
    frameDone <= 1'b0;
  endtask : frames
  // ==========
  // Rounds of traffic, refused accesses and full sweeps
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (n = 0; n < 4; n++) begin
      if (n > 0) frames(40, (n == 3) ? 32'h600 : 32'h5f2);
      wr(`PSC_ADDR_CMD, 16'h0c00 | 16'(n + 2));
      wr(`PSC_ADDR_LOW, 16'(xs()));
      rd(11'h030);
      chk("unmapped", d, 16'h0000);
      wr(`PSC_ADDR_CMD, 16'h1c00 | 16'(n + 2));
      cnt[n + 2] = 0;
      for (o = 0; o < 33; o++) rdctr(o);
    end
    finish_test();
  end
  // Hang guard, well beyond the some 1500 cycles needed
  initial begin
    repeat (32'h2710) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
